// ---- pkg/dsc_pkg.sv ----
// Shared constants and types for the synthesiser and DAC control block
package dsc_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_SYNTH_CTL = 32'hffff_0690;
  localparam logic [31:0] ADDR_FREQ = 32'hffff_0694;
  localparam logic [31:0] ADDR_PHASE = 32'hffff_0698;
  localparam logic [31:0] ADDR_MODE = 32'hffff_06b0;
  localparam logic [31:0] ADDR_SAMPLE = 32'hffff_06b4;
  localparam logic [31:0] ADDR_SRC = 32'hffff_06b8;
  localparam logic [31:0] ADDR_KEY = 32'hffff_06bc;
  localparam logic [31:0] ADDR_STATUS = 32'hffff_06c0;

  // ----------------------------------------------------------------
  // Field layout and codes
  // ----------------------------------------------------------------
  localparam logic [7:0] KEY_FIRST = 8'h07;
  localparam logic [7:0] KEY_SECOND = 8'hb9;
  localparam int SRC_DIRECT_BIT = 0;
  localparam int SYN_EN_BIT = 5;
  localparam int SYN_SCALE_MSB = 3;
  localparam int MODE_LSB = 1;
  localparam int MODE_MSB = 2;
  localparam int MODE_TIMER_BIT = 0;
  localparam logic [1:0] MODE_POWER_DOWN = 2'h0;
  localparam logic [1:0] MODE_ACTIVE = 2'h3;
  localparam int SAMPLE_W = 10;
  localparam int PHASE_W = 12;
  localparam int FREQ_W = 32;
  localparam int SCALE_W = 4;
  localparam int FIFO_DEPTH = 16;
  localparam logic [SAMPLE_W-1:0] MIDSCALE = 10'h000;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [FREQ_W-1:0] FREQ_RST = 32'h0000_0000;
  localparam logic [PHASE_W-1:0] PHASE_RST = 12'h000;
  localparam logic [SAMPLE_W-1:0] SAMPLE_RST = 10'h000;
  localparam logic [SCALE_W-1:0] SCALE_RST = 4'h0;

  // ----------------------------------------------------------------
  // Rates
  // ----------------------------------------------------------------
  localparam int PCLK_HZ = 25_000_000;
  localparam int SYNTH_HZ = 20_889_600;
  localparam int RATE_W = 26;

  typedef enum logic [1:0] {
    KEY_IDLE = 2'b00,
    KEY_ARMED = 2'b01,
    KEY_HELD = 2'b10
  } dsc_key_t;

endpackage

// ---- pkg/dsc_stream_if.sv ----
// Valid/ready sample stream between the block's own modules
`timescale 1ns/10ps
interface dsc_stream_if #(
  parameter int W = 10
);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface

// ---- logic/dsc_sine.sv ----
// Phase to scaled signed sine sample, quarter-wave table
`timescale 1ns/10ps
module dsc_sine
  import dsc_pkg::*;
(
  // Phase and amplitude
  input logic [PHASE_W-1:0] phase,
  input logic [SCALE_W-1:0] scale,
  // Signed sample
  output logic [SAMPLE_W-1:0] sample
);

  // ----------------------------------------------------------------
  // Quarter wave, 16 points, peak 510
  // ----------------------------------------------------------------
  localparam logic [8:0] QTAB [16] = '{
    9'd25, 9'd75, 9'd124, 9'd172, 9'd218, 9'd263, 9'd304, 9'd343,
    9'd379, 9'd410, 9'd438, 9'd462, 9'd481, 9'd496, 9'd505, 9'd510
  };

  logic [3:0] idx;
  logic [8:0] mag;
  logic signed [SAMPLE_W-1:0] raw;
  logic signed [13:0] prod;

  always_comb begin
    idx = phase[PHASE_W-2] ? ~phase[9:6] : phase[9:6];
    mag = QTAB[idx];
    raw = phase[PHASE_W-1] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
    prod = 14'(raw * $signed({1'b0, scale[SCALE_W-2:0]}));
    // Codes with the top bit set pass the sine at unity
    sample = scale[SCALE_W-1] ? raw : prod[12:3];
  end

endmodule

// ---- logic/dsc_fifo.sv ----
// Sample FIFO with valid/ready on both sides
`timescale 1ns/10ps
module dsc_fifo #(
  parameter int W = 10,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input logic pclk,
  input logic presetn,
  input logic flush,
  // Streams
  dsc_stream_if.dst in_s,
  dsc_stream_if.src out_s,
  // Fill level
  output logic [$clog2(DEPTH+1)-1:0] level
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
  } dsc_fifo_st_t;

  dsc_fifo_st_t st_reg;
  dsc_fifo_st_t st_next;
  logic push;
  logic pop;

  assign in_s.ready = st_reg.cnt != CW'(DEPTH);
  assign out_s.valid = st_reg.cnt != '0;
  assign out_s.data = st_reg.mem[st_reg.rp];
  assign level = st_reg.cnt;

  always_comb begin
    st_next = st_reg;
    push = in_s.valid && in_s.ready;
    pop = out_s.valid && out_s.ready;
    if (push) begin
      st_next.mem[st_reg.wp] = in_s.data;
      st_next.wp = (st_reg.wp == AW'(DEPTH-1)) ? '0 : AW'(st_reg.wp + 1'b1);
    end
    if (pop) begin
      st_next.rp = (st_reg.rp == AW'(DEPTH-1)) ? '0 : AW'(st_reg.rp + 1'b1);
    end
    if (push && !pop) begin
      st_next.cnt = CW'(st_reg.cnt + 1'b1);
    end else if (pop && !push) begin
      st_next.cnt = CW'(st_reg.cnt - 1'b1);
    end
    if (flush) begin
      st_next.wp = '0;
      st_next.rp = '0;
      st_next.cnt = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule

// ---- logic/dsc_dac_ctrl.sv ----
// Synthesiser and DAC sample control with APB register slave
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/10ps

module dsc_dac_ctrl
  import dsc_pkg::*;
(
  // Clock and reset
  input logic pclk,
  input logic presetn,
  // APB slave
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [31:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Timer strobe pin
  input logic timer1_in,
  // DAC side
  output logic [SAMPLE_W-1:0] dac_code,
  output logic dac_update,
  output logic dac_power_on,
  output logic synth_active
);

  // ----------------------------------------------------------------
  // Rate constants
  // ----------------------------------------------------------------
  localparam logic [RATE_W-1:0] RATE_STEP = RATE_W'(SYNTH_HZ);
  localparam logic [RATE_W-1:0] RATE_MOD = RATE_W'(PCLK_HZ);
  localparam int LVL_W = $clog2(FIFO_DEPTH+1);
  // Status word layout and key field
  localparam int STAT_KEY_MSB = 1;
  localparam int STAT_SYNTH_BIT = 2;
  localparam int STAT_POWER_BIT = 3;
  localparam int STAT_LVL_LSB = 8;
  localparam int KEY_BYTE_MSB = 7;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    dsc_key_t key;
    logic pend_sample;
    logic [SAMPLE_W-1:0] pend_data;
    logic src_direct;
    logic [SAMPLE_W-1:0] sample;
    logic [FREQ_W-1:0] freq;
    logic [PHASE_W-1:0] phase;
    logic syn_en;
    logic [SCALE_W-1:0] scale;
    logic [1:0] mode;
    logic upd_timer;
    logic [RATE_W-1:0] rate_acc;
    logic [FREQ_W-1:0] acc;
    logic t1_s1;
    logic t1_s2;
    logic t1_d;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [SAMPLE_W-1:0] dac_code;
    logic dac_update;
    logic power_on;
    logic synth_active;
  } dsc_st_t;

  dsc_st_t r;
  dsc_st_t n;

  // ----------------------------------------------------------------
  // Sample path
  // ----------------------------------------------------------------
  dsc_stream_if #(.W(SAMPLE_W)) gen_s ();
  dsc_stream_if #(.W(SAMPLE_W)) dac_s ();

  logic [SAMPLE_W-1:0] sine_sample;
  logic [PHASE_W-1:0] sine_phase;
  logic [LVL_W-1:0] fifo_level;
  logic synth_on;
  logic flush;
  logic tick;
  logic [RATE_W-1:0] rate_sum;

  // Offset adds modulo a full turn
  assign sine_phase = PHASE_W'(r.acc[FREQ_W-1 -: PHASE_W] + r.phase);

  dsc_sine u_sine (
    .phase(sine_phase),
    .scale(r.scale),
    .sample(sine_sample)
  );

  dsc_fifo #(.W(SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .flush(flush),
    .in_s(gen_s),
    .out_s(dac_s),
    .level(fifo_level)
  );

  // Synth runs only in active mode with itself as source and enabled
  assign synth_on = (r.mode == MODE_ACTIVE) && !r.src_direct && r.syn_en;
  assign flush = !synth_on;

  // Generator keeps the FIFO full; the accumulator steps once per sample,
  // so the output rate is set by the drain tick, not by pclk.
  assign gen_s.valid = synth_on;
  assign gen_s.data = sine_sample;
  assign dac_s.ready = synth_on && tick;

  // ----------------------------------------------------------------
  // Fractional divider: 20.8896 MHz enable from 25 MHz
  // ----------------------------------------------------------------
  always_comb begin
    rate_sum = RATE_W'(r.rate_acc + RATE_STEP);
    tick = rate_sum >= RATE_MOD;
  end

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  function automatic logic [31:0] read_word(input dsc_st_t s, input logic [31:0] a,
                                            input logic [LVL_W-1:0] lvl);
    logic [31:0] d;
    d = '0;
    case (a)
      ADDR_SYNTH_CTL: begin
        d[SYN_EN_BIT] = s.syn_en;
        d[SYN_SCALE_MSB:0] = s.scale;
      end
      ADDR_FREQ: begin
        d = s.freq;
      end
      ADDR_PHASE: begin
        d[PHASE_W-1:0] = s.phase;
      end
      ADDR_MODE: begin
        d[MODE_MSB:MODE_LSB] = s.mode;
        d[MODE_TIMER_BIT] = s.upd_timer;
      end
      ADDR_SAMPLE: begin
        d[SAMPLE_W-1:0] = s.sample;
      end
      ADDR_SRC: begin
        d[SRC_DIRECT_BIT] = s.src_direct;
      end
      ADDR_STATUS: begin
        d[STAT_KEY_MSB:0] = s.key;
        d[STAT_SYNTH_BIT] = s.synth_active;
        d[STAT_POWER_BIT] = s.power_on;
        d[STAT_LVL_LSB +: LVL_W] = lvl;
      end
      default: begin
        d = '0;
      end
    endcase
    return d;
  endfunction

  function automatic logic mapped(input logic [31:0] a);
    logic m;
    m = (a == ADDR_SYNTH_CTL) || (a == ADDR_FREQ) || (a == ADDR_PHASE) ||
        (a == ADDR_MODE) || (a == ADDR_SAMPLE) || (a == ADDR_SRC) ||
        (a == ADDR_KEY) || (a == ADDR_STATUS);
    return m;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic wr_commit;
  logic direct_strobe;
  logic t1_fall;

  always_comb begin
    n = r;
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    n.dac_update = 1'b0;

    // Pin synchroniser; the edge detector compares the second stage with its delayed copy
    n.t1_s1 = timer1_in;
    n.t1_s2 = r.t1_s1;
    n.t1_d = r.t1_s2;
    t1_fall = r.t1_d && !r.t1_s2;

    // APB: one wait state, data and error captured with pready
    if (psel && penable && !r.pready) begin
      n.pready = 1'b1;
      n.pslverr = !mapped(paddr);
      n.prdata = pwrite ? 32'h0000_0000 : read_word(r, paddr, fifo_level);
    end
    wr_commit = psel && penable && r.pready && pwrite;

    if (wr_commit) begin
      // Any write not continuing the unlock sequence drops it
      n.key = KEY_IDLE;
      case (paddr)
        ADDR_KEY: begin
          if (pwdata[KEY_BYTE_MSB:0] == KEY_FIRST) begin
            n.key = KEY_ARMED;
          end else if (pwdata[KEY_BYTE_MSB:0] == KEY_SECOND && r.key == KEY_HELD) begin
            if (r.pend_sample) begin
              n.sample = r.pend_data;
            end else begin
              n.src_direct = r.pend_data[SRC_DIRECT_BIT];
            end
          end
        end
        ADDR_SAMPLE, ADDR_SRC: begin
          // Value is held aside until the closing key arrives
          if (r.key == KEY_ARMED) begin
            n.key = KEY_HELD;
            n.pend_sample = (paddr == ADDR_SAMPLE);
            n.pend_data = pwdata[SAMPLE_W-1:0];
          end
        end
        ADDR_SYNTH_CTL: begin
          n.syn_en = pwdata[SYN_EN_BIT];
          n.scale = pwdata[SYN_SCALE_MSB:0];
        end
        ADDR_FREQ: begin
          n.freq = pwdata;
        end
        ADDR_PHASE: begin
          n.phase = pwdata[PHASE_W-1:0];
        end
        ADDR_MODE: begin
          n.mode = pwdata[MODE_MSB:MODE_LSB];
          n.upd_timer = pwdata[MODE_TIMER_BIT];
        end
        default: begin
          n.key = KEY_IDLE;
        end
      endcase
    end

    // Synthesiser phase and rate
    n.rate_acc = tick ? RATE_W'(rate_sum - RATE_MOD) : rate_sum;
    if (!synth_on) begin
      n.acc = '0;
    end else if (gen_s.valid && gen_s.ready) begin
      n.acc = FREQ_W'(r.acc + r.freq);
    end

    // Direct mode update strobe: timer falling edge or every core clock
    direct_strobe = r.upd_timer ? t1_fall : 1'b1;

    n.power_on = (r.mode == MODE_ACTIVE);
    n.synth_active = synth_on;
    if (r.mode != MODE_ACTIVE) begin
      // Power-down and reserved codes park the output at midscale
      n.dac_code = MIDSCALE;
    end else if (r.src_direct) begin
      if (direct_strobe) begin
        n.dac_code = r.sample;
        n.dac_update = 1'b1;
      end
    end else if (!r.syn_en) begin
      n.dac_code = MIDSCALE;
    end else if (dac_s.valid && dac_s.ready) begin
      n.dac_code = dac_s.data;
      n.dac_update = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.key <= KEY_IDLE;
      r.sample <= SAMPLE_RST;
      r.freq <= FREQ_RST;
      r.phase <= PHASE_RST;
      r.scale <= SCALE_RST;
      r.mode <= MODE_POWER_DOWN;
      r.dac_code <= MIDSCALE;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign dac_code = r.dac_code;
  assign dac_update = r.dac_update;
  assign dac_power_on = r.power_on;
  assign synth_active = r.synth_active;

endmodule

// ---- dv/dsc_dac_ctrl_asserts.sv ----
// Port-level checker for the synthesiser and DAC control block
`timescale 1ns/10ps
module dsc_dac_ctrl_asserts
  import dsc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Timer and DAC side
  input wire logic timer1_in,
  input wire logic [SAMPLE_W-1:0] dac_code,
  input wire logic dac_update,
  input wire logic dac_power_on,
  input wire logic synth_active
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_one_wait: assert property ((psel && !penable) |-> ##2 pready)
    else $error("pready not two cycles after setup");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_err_reads_zero: assert property (pready && pslverr |-> prdata == 32'h0000_0000)
    else $error("refused access returned data");
  a_off_midscale: assert property (!dac_power_on ##1 !dac_power_on |-> dac_code == MIDSCALE)
    else $error("powered down code not midscale");
  a_off_quiet: assert property (!dac_power_on ##1 !dac_power_on |-> !dac_update && !synth_active)
    else $error("activity while powered down");
  a_synth_no_gap: assert property (synth_active [*6] |-> dac_update || $past(dac_update))
    else $error("synthesiser stream stalled");
  c_synth: cover property (synth_active && dac_update);
  c_refused: cover property (pslverr);
  c_direct: cover property (dac_update && dac_power_on && !synth_active);
endmodule

bind dsc_dac_ctrl dsc_dac_ctrl_asserts chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .timer1_in(timer1_in), .dac_code(dac_code),
  .dac_update(dac_update), .dac_power_on(dac_power_on), .synth_active(synth_active));

// ---- dv/dsc_dac_model.sv ----
// Behavioural DAC converter: captures loaded codes and the output level
`timescale 1ns/10ps
module dsc_dac_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clr,
  // Codes from the block
  input wire logic [9:0] dac_code,
  input wire logic dac_update,
  input wire logic dac_power_on,
  // Observed conversion
  output logic [9:0] level,
  output logic [3:0][9:0] caps,
  output logic [15:0] n
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n <= '0;
      caps <= '0;
      level <= 10'h200;
    end else if (clr) begin
      n <= '0;
    end else if (dac_update && dac_power_on) begin
      if (n < 16'h0004) caps[n[1:0]] <= dac_code;
      n <= n + 16'h0001;
      // Signed code to unsigned ladder level, so code zero sits at midscale
      level <= dac_code ^ 10'h200;
    end
  end
endmodule

// ---- dv/test_dds_sine_dac_control.sv ----
// Self-checking bench for the synthesiser and DAC control block
`timescale 1ns/10ps
module test_dds_sine_dac_control
  import dsc_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, timer1_in = 1, clr = 0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
  logic pready, pslverr, er, dac_update, dac_power_on, synth_active;
  logic [9:0] dac_code, level;
  logic [3:0][9:0] caps;
  logic [15:0] n;
  int bad_count = 0, check_count = 0, i;
  always #20 pclk = ~pclk;
  dsc_dac_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer1_in(timer1_in), .dac_code(dac_code), .dac_update(dac_update),
    .dac_power_on(dac_power_on), .synth_active(synth_active));
  dsc_dac_model dac_u (.pclk(pclk), .presetn(presetn), .clr(clr), .dac_code(dac_code),
    .dac_update(dac_update), .dac_power_on(dac_power_on), .level(level), .caps(caps), .n(n));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic fail_wait();
    bad_count++;
    $display("wrong value at %0t: wait ran out", $time);
    give_verdict();
  endtask
  // Caller is just past a rising edge; the request is held until pready
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int k;
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 20) fail_wait();
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask
  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
    apb(0, a, 32'h0000_0000);
    cmp(rd, exp);
  endtask
  task automatic prot(input logic [31:0] a, input logic [31:0] d);
    wr(ADDR_KEY, {24'h00_0000, KEY_FIRST});
    wr(a, d);
    wr(ADDR_KEY, {24'h00_0000, KEY_SECOND});
  endtask
  task automatic wait_n(input int m);
    for (i = 0; i < 60 && n < m[15:0]; i++) @(posedge pclk);
    if (i == 60) fail_wait();
  endtask
  task automatic pulse_clr();
    clr <= 1;
    @(posedge pclk);
    clr <= 0;
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    rdchk(ADDR_FREQ, FREQ_RST);
    rdchk(ADDR_PHASE, 32'h0000_0000);
    rdchk(ADDR_SAMPLE, 32'h0000_0000);
    rdchk(ADDR_SRC, 32'h0000_0000);
    wr(ADDR_FREQ, 32'h1234_5678);
    rdchk(ADDR_FREQ, 32'h1234_5678);
    wr(ADDR_PHASE, 32'hffff_ffff);
    rdchk(ADDR_PHASE, 32'h0000_0fff);
    wr(32'hffff_06c4, 32'h0000_0001);
    cmp(er, 1);
    rdchk(32'hffff_06c4, 32'h0000_0000);
    wr(ADDR_SAMPLE, 32'h0000_0155);
    rdchk(ADDR_SAMPLE, 32'h0000_0000);
    wr(ADDR_KEY, 32'h0000_0007);
    // Status shows the tracker armed; a read must not disturb it
    rdchk(ADDR_STATUS, 32'h0000_0001);
    wr(ADDR_SAMPLE, 32'h0000_0155);
    wr(ADDR_KEY, 32'h0000_00aa);
    rdchk(ADDR_SAMPLE, 32'h0000_0000);
    wr(ADDR_KEY, 32'h0000_0007);
    wr(ADDR_SAMPLE, 32'h0000_0155);
    wr(ADDR_FREQ, 32'h0400_0000);
    wr(ADDR_KEY, 32'h0000_00b9);
    rdchk(ADDR_SAMPLE, 32'h0000_0000);
    wr(ADDR_PHASE, 32'h0000_0000);
    wr(ADDR_MODE, 32'h0000_0006);
    prot(ADDR_SRC, 32'h0000_0001);
    prot(ADDR_SAMPLE, 32'hffff_fe00);
    rdchk(ADDR_SAMPLE, 32'h0000_0200);
    cmp(dac_code, 32'h0000_0200);
    cmp(level, 32'h0000_0000);
    cmp(dac_power_on, 1);
    prot(ADDR_SAMPLE, 32'h0000_01ff);
    // Code is loaded one edge after commit and the converter takes it one edge later
    repeat (2) @(posedge pclk);
    cmp(level, 32'h0000_03ff);
    wr(ADDR_MODE, 32'h0000_0007);
    prot(ADDR_SAMPLE, 32'h0000_0000);
    cmp(dac_code, 32'h0000_01ff);
    timer1_in <= 0;
    for (i = 0; i < 10 && dac_update !== 1'b1; i++) @(posedge pclk);
    if (i == 10) fail_wait();
    cmp(dac_code, 32'h0000_0000);
    timer1_in <= 1;
    wr(ADDR_MODE, 32'h0000_0006);
    prot(ADDR_SRC, 32'h0000_0000);
    pulse_clr();
    wr(ADDR_SYNTH_CTL, 32'h0000_0028);
    wait_n(4);
    cmp(caps, {10'd172, 10'd124, 10'd75, 10'd25});
    pulse_clr();
    repeat (600) @(posedge pclk);
    cmp(n >= 16'd500 && n <= 16'd503, 1);
    wr(ADDR_SYNTH_CTL, 32'h0000_0008);
    repeat (3) @(posedge pclk);
    cmp(synth_active, 0);
    cmp(dac_code, 32'h0000_0000);
    wr(ADDR_PHASE, 32'h0000_0400);
    pulse_clr();
    wr(ADDR_SYNTH_CTL, 32'h0000_0024);
    wait_n(2);
    cmp(caps[1:0], {10'd252, 10'd255});
    // Reserved mode code behaves as powered down
    wr(ADDR_MODE, 32'h0000_0004);
    repeat (3) @(posedge pclk);
    cmp(dac_power_on, 0);
    cmp(synth_active, 0);
    cmp(dac_code, 32'h0000_0000);
    wr(ADDR_MODE, 32'h0000_0000);
    repeat (3) @(posedge pclk);
    cmp(dac_power_on, 0);
    cmp(synth_active, 0);
    give_verdict();
  end
endmodule
